// [design/dmf_top.sv]
// Summary of operation
// - five-bit type field; codes 0..4 name the five doorbell kinds
// - broadcast skips processor tag compare, partition must still match
// - partition tag mismatch rejects the message always
// - processor doorbells compare tag with processor id low fourteen bits
// - guest doorbells compare tag with guest processor id instead
// - acceptance raises the pending exception of that message type
// - pending holds until interrupt taken, clear of that type, or a write-one to its pending register bit
// - later identifier changes never clear a pending exception
// - pending bits do not count; repeats leave one pending
// - every privileged send with stores done goes out, others are refused; every seen message is filtered here
// - outgoing messages carry a dedicated transaction type only sends make
// - any payload may be sent but sending needs hypervisor privilege
// - sends not ordered with memory except stores before barrier
// - guest doorbells interrupt only in guest state with matching enable
// - all to hypervisor; base, guest and critical save pairs as typed
// - guest critical and guest machine check share one vector
// - priority: guest mc, proc crit, guest crit, proc db, guest db
//
// Design decisions made here: the placing of the registers and the strobed register port.
module dmf_top
  import dmf_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic SEND,
  input wire logic [63:0] SEND_OPERAND,
  input wire logic HYP_PRIV,
  input wire logic STORES_DONE,
  output logic SEND_REFUSED,
  output dmf_pkg::dmf_msg_t TX_MSG,
  input wire dmf_pkg::dmf_msg_t RX_MSG,
  input wire logic CLEAR,
  input wire logic [4:0] CLEAR_TYPE,
  input wire logic TAKE_ACK,
  output dmf_pkg::dmf_take_t TAKE_REQ,
  output logic IRQ
);
  import dmf_pkg::*;

  logic [31:0] pid, next_pid;
  logic [31:0] gpid, next_gpid;
  logic [7:0] part, next_part;
  logic [3:0] state, next_state;
  logic [4:0] pend, next_pend;
  logic [4:0] mask, next_mask;
  logic [31:0] rdata, next_rdata;
  dmf_msg_t tx, next_tx;
  logic refused, next_refused;
  dmf_msg_t rx_q;
  logic [4:0] hit;
  logic [4:0] clr;
  logic [4:0] ready;
  dmf_take_t take;

  // state bits: 0 external enable, 1 critical enable, 2 machine check enable, 3 guest state
  wire ee = state[0];
  wire ce = state[1];
  wire me = state[2];
  wire gs = state[3];

  function automatic logic [4:0] type_onehot(input logic [4:0] code);
    logic [4:0] v;
    v = 5'h00;
    if (code < 5'(NUM_TYPES)) begin
      v[code[2:0]] = 1'b1;
    end
    return v;
  endfunction : type_onehot

  // receive path is registered once; the link is same-clock logic
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_q <= '0;
    end else begin
      rx_q <= RX_MSG;
    end
  end

  // filtering: every dedicated message is examined here
  always_comb begin
    logic [4:0] t;
    logic [13:0] tag;
    logic part_ok;
    logic pid_ok;
    logic gpid_ok;
    t = rx_q.payload[TYPE_LSB +: TYPE_W];
    tag = rx_q.payload[PTAG_LSB +: PTAG_W];
    part_ok = rx_q.payload[PART_LSB +: PART_W] == part;
    pid_ok = rx_q.payload[BCAST_BIT] || (tag == pid[13:0]);
    gpid_ok = rx_q.payload[BCAST_BIT] || (tag == gpid[13:0]);
    hit = 5'h00;
    if (rx_q.valid && rx_q.dedicated && part_ok) begin
      hit = type_onehot(t) & {gpid_ok, gpid_ok, gpid_ok, pid_ok, pid_ok};
    end
  end

  // interrupt eligibility and priority selection
  always_comb begin
    ready[0] = pend[0] & mask[0] & ee;
    ready[1] = pend[1] & mask[1] & ce;
    ready[2] = pend[2] & mask[2] & ee & gs;
    ready[3] = pend[3] & mask[3] & ce & gs;
    ready[4] = pend[4] & mask[4] & me & gs;
    take = '0;
    // highest first; all targets are hypervisor-level handlers
    if (ready[4]) begin
      take = '{valid: 1'b1, save_pair: SAVE_CRIT, vector: VEC_GUEST_CRIT_MC, kind: 3'h4};
    end else if (ready[1]) begin
      take = '{valid: 1'b1, save_pair: SAVE_CRIT, vector: VEC_PROC_CRIT, kind: 3'h1};
    end else if (ready[3]) begin
      take = '{valid: 1'b1, save_pair: SAVE_CRIT, vector: VEC_GUEST_CRIT_MC, kind: 3'h3};
    end else if (ready[0]) begin
      take = '{valid: 1'b1, save_pair: SAVE_BASE, vector: VEC_PROC_DB, kind: 3'h0};
    end else if (ready[2]) begin
      take = '{valid: 1'b1, save_pair: SAVE_GUEST, vector: VEC_GUEST_DB, kind: 3'h2};
    end
  end

  assign TAKE_REQ = take;
  assign IRQ = take.valid;

  // clear sources: taken interrupt, clear instruction, or software write-one
  always_comb begin
    clr = 5'h00;
    if (TAKE_ACK && take.valid) begin
      clr[take.kind] = 1'b1;
    end
    if (CLEAR) begin
      clr = clr | type_onehot(CLEAR_TYPE);
    end
    if (WR && ADDR == REG_PEND) begin
      clr = clr | WDATA[4:0];
    end
  end

  // next values of registers and pending bits; a new hit beats a clear
  always_comb begin
    next_pid = pid;
    next_gpid = gpid;
    next_part = part;
    next_state = state;
    next_mask = mask;
    next_pend = (pend & ~clr) | hit;
    if (WR) begin
      case (ADDR)
        REG_PID: next_pid = WDATA;
        REG_GPID: next_gpid = WDATA;
        REG_PART: next_part = WDATA[7:0];
        REG_STATE: next_state = WDATA[3:0];
        REG_MASK: next_mask = WDATA[4:0];
        default: ;
      endcase
    end
    next_rdata = RESET_VAL;
    if (RD) begin
      case (ADDR)
        REG_PID: next_rdata = pid;
        REG_GPID: next_rdata = gpid;
        REG_PART: next_rdata = {24'h00_0000, part};
        REG_STATE: next_rdata = {28'h000_0000, state};
        REG_PEND: next_rdata = {27'h000_0000, pend};
        REG_MASK: next_rdata = {27'h000_0000, mask};
        default: next_rdata = RESET_VAL;
      endcase
    end
  end

  // send path: privileged, barrier-gated so earlier stores land first
  always_comb begin
    next_tx = '0;
    next_refused = 1'b0;
    if (SEND) begin
      if (!HYP_PRIV) begin
        next_refused = 1'b1;
      end else if (STORES_DONE) begin
        next_tx.valid = 1'b1;
        next_tx.dedicated = 1'b1;
        next_tx.payload = SEND_OPERAND;
      end else begin
        next_refused = 1'b1;
      end
    end
  end

  // register stage for all state except rx_q, which the receive path registers above
  always_ff @(posedge CLK) begin
    if (RST) begin
      pid <= RESET_VAL;
      gpid <= RESET_VAL;
      part <= 8'h00;
      state <= 4'h0;
      pend <= 5'h00;
      mask <= MASK_RESET;
      rdata <= RESET_VAL;
      tx <= '0;
      refused <= 1'b0;
    end else begin
      pid <= next_pid;
      gpid <= next_gpid;
      part <= next_part;
      state <= next_state;
      pend <= next_pend;
      mask <= next_mask;
      rdata <= next_rdata;
      tx <= next_tx;
      refused <= next_refused;
    end
  end

  assign RDATA = rdata;
  assign TX_MSG = tx;
  assign SEND_REFUSED = refused;

  // each accepted type must show up pending on the next edge, whatever else clears it
  pend_set_a: assert property (@(posedge CLK) disable iff (RST)
    hit[0] |=> pend[0]) else $error("accepted doorbell not pending");
  pend_set1_a: assert property (@(posedge CLK) disable iff (RST)
    hit[1] |=> pend[1])
    else $error("accepted critical doorbell not pending");
  pend_set2_a: assert property (@(posedge CLK) disable iff (RST)
    hit[2] |=> pend[2])
    else $error("accepted guest doorbell not pending");
  pend_set3_a: assert property (@(posedge CLK) disable iff (RST)
    hit[3] |=> pend[3])
    else $error("accepted guest critical not pending");
  pend_set4_a: assert property (@(posedge CLK) disable iff (RST)
    hit[4] |=> pend[4])
    else $error("accepted guest machine check not pending");

  // nothing but a hit may raise a pending bit
  pend_quiet0_a: assert property (@(posedge CLK) disable iff (RST)
    (!pend[0] && !hit[0]) |=> !pend[0])
    else $error("doorbell pending without hit");
  pend_quiet1_a: assert property (@(posedge CLK) disable iff (RST)
    (!pend[1] && !hit[1]) |=> !pend[1])
    else $error("critical pending without hit");
  pend_quiet2_a: assert property (@(posedge CLK) disable iff (RST)
    (!pend[2] && !hit[2]) |=> !pend[2])
    else $error("guest pending without hit");
  pend_quiet3_a: assert property (@(posedge CLK) disable iff (RST)
    (!pend[3] && !hit[3]) |=> !pend[3])
    else $error("guest critical pending without hit");
  pend_quiet4_a: assert property (@(posedge CLK) disable iff (RST)
    (!pend[4] && !hit[4]) |=> !pend[4])
    else $error("guest machine check pending without hit");

  // a clear with no competing hit must drop the bit on the next edge
  pend_clear0_a: assert property (@(posedge CLK) disable iff (RST)
    (clr[0] && !hit[0]) |=> !pend[0])
    else $error("doorbell clear ignored");
  pend_clear1_a: assert property (@(posedge CLK) disable iff (RST)
    (clr[1] && !hit[1]) |=> !pend[1])
    else $error("critical clear ignored");
  pend_clear2_a: assert property (@(posedge CLK) disable iff (RST)
    (clr[2] && !hit[2]) |=> !pend[2])
    else $error("guest clear ignored");
  pend_clear3_a: assert property (@(posedge CLK) disable iff (RST)
    (clr[3] && !hit[3]) |=> !pend[3])
    else $error("guest critical clear ignored");
  pend_clear4_a: assert property (@(posedge CLK) disable iff (RST)
    (clr[4] && !hit[4]) |=> !pend[4])
    else $error("guest machine check clear ignored");

  // filter checks: tag compare source depends on the type
  proc_tag_a: assert property (@(posedge CLK) disable iff (RST)
    (rx_q.payload[TYPE_LSB +: TYPE_W] == MSG_PROC_DB && !rx_q.payload[BCAST_BIT]
     && rx_q.payload[PTAG_LSB +: PTAG_W] != pid[13:0]) |-> !hit[0])
    else $error("doorbell tag mismatch accepted");
  crit_tag_a: assert property (@(posedge CLK) disable iff (RST)
    (rx_q.payload[TYPE_LSB +: TYPE_W] == MSG_PROC_DB_CRIT && !rx_q.payload[BCAST_BIT]
     && rx_q.payload[PTAG_LSB +: PTAG_W] != pid[13:0]) |-> !hit[1])
    else $error("critical tag mismatch accepted");
  guest_tag_a: assert property (@(posedge CLK) disable iff (RST)
    (rx_q.payload[TYPE_LSB +: TYPE_W] == MSG_GUEST_DB && !rx_q.payload[BCAST_BIT]
     && rx_q.payload[PTAG_LSB +: PTAG_W] != gpid[13:0]) |-> !hit[2])
    else $error("guest tag mismatch accepted");
  gcrit_tag_a: assert property (@(posedge CLK) disable iff (RST)
    (rx_q.payload[TYPE_LSB +: TYPE_W] == MSG_GUEST_DB_CRIT && !rx_q.payload[BCAST_BIT]
     && rx_q.payload[PTAG_LSB +: PTAG_W] != gpid[13:0]) |-> !hit[3])
    else $error("guest critical tag mismatch accepted");
  gmc_tag_a: assert property (@(posedge CLK) disable iff (RST)
    (rx_q.payload[TYPE_LSB +: TYPE_W] == MSG_GUEST_DB_MC && !rx_q.payload[BCAST_BIT]
     && rx_q.payload[PTAG_LSB +: PTAG_W] != gpid[13:0]) |-> !hit[4])
    else $error("guest machine check tag mismatch accepted");
  proc_accept_a: assert property (@(posedge CLK) disable iff (RST)
    (rx_q.valid && rx_q.dedicated && rx_q.payload[TYPE_LSB +: TYPE_W] == MSG_PROC_DB
     && rx_q.payload[PART_LSB +: PART_W] == part
     && rx_q.payload[PTAG_LSB +: PTAG_W] == pid[13:0]) |-> hit[0])
    else $error("matching doorbell refused");
  guest_accept_a: assert property (@(posedge CLK) disable iff (RST)
    (rx_q.valid && rx_q.dedicated && rx_q.payload[TYPE_LSB +: TYPE_W] == MSG_GUEST_DB
     && rx_q.payload[PART_LSB +: PART_W] == part
     && rx_q.payload[PTAG_LSB +: PTAG_W] == gpid[13:0]) |-> hit[2])
    else $error("matching guest doorbell refused");
  plain_txn_a: assert property (@(posedge CLK) disable iff (RST)
    !rx_q.dedicated |-> hit == 5'h00)
    else $error("ordinary transaction accepted");
  one_type_a: assert property (@(posedge CLK) disable iff (RST)
    $onehot0(hit))
    else $error("one message hit several types");

  // interrupt side: gating, priority and save pair per kind
  irq_pend_a: assert property (@(posedge CLK) disable iff (RST)
    IRQ |-> (pend & mask) != 5'h00)
    else $error("interrupt without unmasked pending bit");
  proc_gate_a: assert property (@(posedge CLK) disable iff (RST)
    (take.valid && take.kind == 3'h0) |-> (ee && pend[0]))
    else $error("doorbell taken while disabled");
  crit_gate_a: assert property (@(posedge CLK) disable iff (RST)
    (take.valid && take.kind == 3'h1) |-> (ce && pend[1]))
    else $error("critical doorbell taken while disabled");
  gcrit_gate_a: assert property (@(posedge CLK) disable iff (RST)
    (take.valid && take.kind == 3'h3) |-> (gs && ce))
    else $error("guest critical ungated");
  gmc_gate_a: assert property (@(posedge CLK) disable iff (RST)
    (take.valid && take.kind == 3'h4) |-> (gs && me))
    else $error("guest machine check ungated");
  mc_first_a: assert property (@(posedge CLK) disable iff (RST)
    ready[4] |-> take.kind == 3'h4)
    else $error("guest machine check outranked");
  crit_next_a: assert property (@(posedge CLK) disable iff (RST)
    (ready[1] && !ready[4]) |-> take.kind == 3'h1)
    else $error("critical doorbell outranked");
  gcrit_next_a: assert property (@(posedge CLK) disable iff (RST)
    (ready[3] && !ready[4] && !ready[1]) |-> take.kind == 3'h3)
    else $error("guest critical outranked");
  db_next_a: assert property (@(posedge CLK) disable iff (RST)
    (ready[0] && !ready[4] && !ready[1] && !ready[3]) |-> take.kind == 3'h0)
    else $error("doorbell outranked");
  save_base_a: assert property (@(posedge CLK) disable iff (RST)
    (take.valid && take.kind == 3'h0) |-> take.save_pair == SAVE_BASE)
    else $error("doorbell save pair wrong");
  save_guest_a: assert property (@(posedge CLK) disable iff (RST)
    (take.valid && take.kind == 3'h2) |-> take.save_pair == SAVE_GUEST)
    else $error("guest doorbell save pair wrong");
  save_crit_a: assert property (@(posedge CLK) disable iff (RST)
    (take.valid && take.kind inside {3'h1, 3'h3, 3'h4}) |-> take.save_pair == SAVE_CRIT)
    else $error("critical save pair wrong");

  // send side: only an accepted send makes a dedicated transaction; then further filter, pending, gate, vector and send checks
  stores_gate_a: assert property (@(posedge CLK) disable iff (RST)
    (SEND && HYP_PRIV && !STORES_DONE) |=> (!TX_MSG.valid && SEND_REFUSED))
    else $error("send overtook earlier stores");
  tx_idle_a: assert property (@(posedge CLK) disable iff (RST)
    !SEND |=> !TX_MSG.valid)
    else $error("transaction without send");
  tx_ded_a: assert property (@(posedge CLK) disable iff (RST)
    TX_MSG.valid |-> TX_MSG.dedicated)
    else $error("send without dedicated type");
  part_rej_a: assert property (@(posedge CLK) disable iff (RST)
    (rx_q.payload[PART_LSB +: PART_W] != part) |-> hit == 5'h00) else $error("partition mismatch hit");
  bad_type_a: assert property (@(posedge CLK) disable iff (RST)
    (rx_q.payload[TYPE_LSB +: TYPE_W] > 5'h04) |-> hit == 5'h00) else $error("bad type accepted");
  pend_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (pend[2] && !clr[2]) |=> pend[2]) else $error("pending dropped without clear");
  pend0_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (pend[0] && !clr[0]) |=> pend[0])
    else $error("doorbell dropped without clear");
  pend1_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (pend[1] && !clr[1]) |=> pend[1])
    else $error("critical dropped without clear");
  pend3_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (pend[3] && !clr[3]) |=> pend[3])
    else $error("guest critical dropped without clear");
  pend4_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (pend[4] && !clr[4]) |=> pend[4])
    else $error("guest machine check dropped without clear");
  guest_gate_a: assert property (@(posedge CLK) disable iff (RST)
    (take.valid && take.kind == 3'h2) |-> (gs && ee)) else $error("guest doorbell ungated");
  vec_share_a: assert property (@(posedge CLK) disable iff (RST)
    (take.valid && take.kind inside {3'h3, 3'h4}) |-> take.vector == VEC_GUEST_CRIT_MC) else $error("vector split");
  send_priv_a: assert property (@(posedge CLK) disable iff (RST)
    (SEND && !HYP_PRIV) |=> (!TX_MSG.valid && SEND_REFUSED)) else $error("unprivileged send");
  send_copy_a: assert property (@(posedge CLK) disable iff (RST)
    (SEND && HYP_PRIV && STORES_DONE) |=> (TX_MSG.dedicated && TX_MSG.payload == $past(SEND_OPERAND))) else $error("send lost");
  bcast_accept_a: assert property (@(posedge CLK) disable iff (RST)
    (rx_q.valid && rx_q.dedicated && rx_q.payload[BCAST_BIT] && rx_q.payload[TYPE_LSB +: TYPE_W] == 5'h01
     && rx_q.payload[PART_LSB +: PART_W] == part) |-> hit[1]) else $error("broadcast not accepted");
endmodule : dmf_top

// [inc/dmf_pkg.sv]
package dmf_pkg;
  // send operand bit positions, counted from the lsb of a 64-bit word
  localparam int TYPE_LSB = 27;
  localparam int TYPE_W = 5;
  localparam int BCAST_BIT = 26;
  localparam int PART_LSB = 14;
  localparam int PART_W = 8;
  localparam int PTAG_LSB = 0;
  localparam int PTAG_W = 14;
  localparam logic [4:0] MSG_PROC_DB = 5'h00;
  localparam logic [4:0] MSG_PROC_DB_CRIT = 5'h01;
  localparam logic [4:0] MSG_GUEST_DB = 5'h02;
  localparam logic [4:0] MSG_GUEST_DB_CRIT = 5'h03;
  localparam logic [4:0] MSG_GUEST_DB_MC = 5'h04;
  localparam int NUM_TYPES = 5;
  // register map
  localparam logic [3:0] REG_PID = 4'h0;
  localparam logic [3:0] REG_GPID = 4'h1;
  localparam logic [3:0] REG_PART = 4'h2;
  localparam logic [3:0] REG_STATE = 4'h3;
  localparam logic [3:0] REG_PEND = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h5;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  localparam logic [4:0] MASK_RESET = 5'h1f;
  // save pair select and vector codes
  localparam logic [1:0] SAVE_BASE = 2'h0;
  localparam logic [1:0] SAVE_CRIT = 2'h1;
  localparam logic [1:0] SAVE_GUEST = 2'h2;
  localparam logic [2:0] VEC_PROC_DB = 3'h0;
  localparam logic [2:0] VEC_PROC_CRIT = 3'h1;
  localparam logic [2:0] VEC_GUEST_DB = 3'h2;
  localparam logic [2:0] VEC_GUEST_CRIT_MC = 3'h3;

  typedef struct packed {
    logic valid;
    logic dedicated;
    logic [63:0] payload;
  } dmf_msg_t;

  typedef struct packed {
    logic valid;
    logic [1:0] save_pair;
    logic [2:0] vector;
    logic [2:0] kind;
  } dmf_take_t;
endpackage : dmf_pkg

// [bench/dmf_peer.sv]
module dmf_peer
  import dmf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic ded,
  input wire logic [63:0] word,
  output dmf_pkg::dmf_msg_t msg
);
  // every word handed in goes out once; an idle bus never repeats it
  always_ff @(posedge clk) begin
    msg.valid <= go & ~rst;
    msg.dedicated <= go & ded;
    msg.payload <= rst ? 64'h0 : (go ? word : ~msg.payload);
  end
endmodule : dmf_peer

// [bench/doorbell_message_filter_tb.sv]
module doorbell_message_filter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dmf_pkg::*;
  logic clk, rst, wr, rd, snd, hyp, sdone, clr, ack, go, ded, refused, irq;
  logic [3:0] addr;
  logic [4:0] ctype;
  logic [31:0] wdata, rdata, v;
  logic [63:0] op, word;
  dmf_msg_t tx, rx;
  dmf_take_t take;
  int n_mismatch = 0;
  int n_checks = 0;

  dmf_top dmf_top_i (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SEND(snd), .SEND_OPERAND(op), .HYP_PRIV(hyp), .STORES_DONE(sdone),
    .SEND_REFUSED(refused), .TX_MSG(tx), .RX_MSG(rx), .CLEAR(clr), .CLEAR_TYPE(ctype),
    .TAKE_ACK(ack), .TAKE_REQ(take), .IRQ(irq));
  dmf_peer dmf_peer_i (.clk(clk), .rst(rst), .go(go), .ded(ded), .word(word), .msg(rx));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // operand word: type, broadcast, reserved, partition, tag
  function automatic logic [63:0] mk(logic [4:0] t, logic b, logic [7:0] p, logic [13:0] g);
    return {32'h0000_0000, t, b, 4'h0, p, g};
  endfunction : mk

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wreg

  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 v = rdata;
  endtask : rreg

  // pend lands two cycles after the peer's pulse; four edges leave margin
  task automatic msg(input logic [63:0] w, input logic d);
    @(posedge clk);
    word <= w;
    ded <= d;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (4) @(posedge clk);
  endtask : msg

  task automatic pulse(input logic is_clear, input logic [4:0] t);
    @(posedge clk);
    ctype <= t;
    clr <= is_clear;
    ack <= ~is_clear;
    @(posedge clk);
    clr <= 1'h0;
    ack <= 1'h0;
  endtask : pulse

  task automatic look(input logic [9:0] exp);
    @(posedge clk);
    #1 chk({22'h0, irq, take}, {22'h0, exp});
  endtask : look

  task automatic send(input logic h, input logic s);
    @(posedge clk);
    snd <= 1'h1;
    op <= mk(5'h1f, 1'h1, 8'hff, 14'h3fff);
    hyp <= h;
    sdone <= s;
    @(posedge clk);
    snd <= 1'h0;
    #1 chk({29'h0, tx.valid, tx.dedicated, refused}, (h & s) ? 32'h6 : 32'h1);
    if (h & s) chk(tx.payload[31:0], op[31:0]);
  endtask : send

  // a hang counts against the run
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    {rst, wr, rd, snd, hyp, sdone, clr, ack, go, ded} = 10'h200;
    {addr, ctype, wdata, op, word} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    rreg(REG_MASK);
    chk(v, 32'h0000_001f);
    wreg(REG_PID, 32'h0000_c005);
    wreg(REG_GPID, 32'h0000_0009);
    wreg(REG_PART, 32'h0000_003c);
    // wrong id register first, then the right one
    for (int t = 0; t < 5; t++) begin
      msg(mk(t[4:0], 1'h0, 8'h3c, t < 2 ? 14'h0009 : 14'h0005), 1'h1);
      msg(mk(t[4:0], 1'h0, 8'h3c, t < 2 ? 14'h0005 : 14'h0009), 1'h1);
      rreg(REG_PEND);
      chk(v, 32'h1 << t);
      wreg(REG_PEND, 32'h1 << t);
    end
    msg(mk(5'h00, 1'h1, 8'h3d, 14'h0005), 1'h1);
    msg(mk(5'h05, 1'h1, 8'h3c, 14'h0005), 1'h1);
    msg(mk(5'h01, 1'h0, 8'h3c, 14'h0005), 1'h0);
    msg(mk(5'h00, 1'h1, 8'h3c, 14'h0077), 1'h1);
    rreg(REG_PEND);
    chk(v, 32'h0000_0001);
    wreg(REG_PID, 32'h0000_0000);
    msg(mk(5'h00, 1'h1, 8'h3c, 14'h0000), 1'h1);
    rreg(REG_PEND);
    chk(v, 32'h0000_0001);
    wreg(REG_STATE, 32'h0000_0001);
    look({2'h3, SAVE_BASE, VEC_PROC_DB, 3'h0});
    pulse(1'h0, 5'h00);
    rreg(REG_PEND);
    chk(v, 32'h0000_0000);
    msg(mk(5'h02, 1'h0, 8'h3c, 14'h0009), 1'h1);
    look(10'h000);
    wreg(REG_STATE, 32'h0000_0009);
    look({2'h3, SAVE_GUEST, VEC_GUEST_DB, 3'h2});
    wreg(REG_MASK, 32'h0000_001b);
    look(10'h000);
    wreg(REG_MASK, 32'h0000_001f);
    pulse(1'h1, 5'h03);
    rreg(REG_PEND);
    chk(v, 32'h0000_0004);
    pulse(1'h1, 5'h02);
    rreg(REG_PEND);
    chk(v, 32'h0000_0000);
    wreg(REG_STATE, 32'h0000_000a);
    msg(mk(5'h03, 1'h0, 8'h3c, 14'h0009), 1'h1);
    look({2'h3, SAVE_CRIT, VEC_GUEST_CRIT_MC, 3'h3});
    pulse(1'h1, 5'h03);
    wreg(REG_STATE, 32'h0000_000c);
    msg(mk(5'h04, 1'h0, 8'h3c, 14'h0009), 1'h1);
    look({2'h3, SAVE_CRIT, VEC_GUEST_CRIT_MC, 3'h4});
    // critical doorbell waits behind the guest machine check until that is taken
    wreg(REG_STATE, 32'h0000_000e);
    msg(mk(5'h01, 1'h1, 8'h3c, 14'h0000), 1'h1);
    look({2'h3, SAVE_CRIT, VEC_GUEST_CRIT_MC, 3'h4});
    pulse(1'h0, 5'h00);
    look({2'h3, SAVE_CRIT, VEC_PROC_CRIT, 3'h1});
    for (int i = 0; i < 4; i++) send(i[1], i[0]);
    tally_and_finish();
  end
endmodule : doorbell_message_filter_tb
